/* hdl/pmc_pkg.sv */
// Shared definitions of the power mode controller: register map, control fields,
// operating modes, debug command codes and regulator states.
// Assumes a 32-bit APB master and a bus clock of 20 MHz.
package pmc_pkg;

	localparam int          APB_AW      = 8;
	localparam int          APB_DW      = 32;
	localparam logic [7:0]  OFFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFFS_STATUS = 8'h04;
	localparam logic [7:0]  OFFS_ACK    = 8'h08;

	// Control register, bit 6 downward.
	typedef struct packed {
		logic ext_ref_stop_keep;
		logic wake_to_full_regulation;
		logic low_power_run_request;
		logic partial_powerdown_select;
		logic lowvolt_detect_in_stop;
		logic lowvolt_detect_enable;
		logic stop_instruction_allow;
	} pmc_ctrl_t;

	localparam int        CTRL_W     = 7;
	localparam pmc_ctrl_t CTRL_RESET = 7'h00;

	// Status register fields.
	localparam int STAT_MODE_LSB   = 0;
	localparam int STAT_STBY_BIT   = 4;
	localparam int STAT_RCVR_BIT   = 5;
	localparam int STAT_IOHOLD_BIT = 6;
	localparam int STAT_DBGCLK_BIT = 7;

	// Acknowledge register: writing one here opens the I/O latches.
	localparam int ACK_BIT = 0;

	typedef enum logic [2:0] {
		MODE_RUN   = 3'h0,
		MODE_WAIT  = 3'h1,
		MODE_BKGD  = 3'h2,
		MODE_STOP3 = 3'h3,
		MODE_STOP2 = 3'h4
	} pmc_mode_t;

	typedef enum logic [2:0] {
		CMD_MEM        = 3'h0,
		CMD_MEM_STAT   = 3'h1,
		CMD_DREG       = 3'h2,
		CMD_BACKGROUND = 3'h3,
		CMD_CPUREG     = 3'h4,
		CMD_TRACE      = 3'h5,
		CMD_GO         = 3'h6
	} pmc_cmd_t;

	typedef enum logic [1:0] {
		REG_FULL    = 2'h0,
		REG_STANDBY = 2'h1,
		REG_PARTIAL = 2'h2
	} pmc_reg_t;

	typedef struct packed {
		logic valid;
		logic exec;
		logic mode_err;
	} pmc_resp_t;

	localparam pmc_resp_t   RESP_IDLE = 3'h0;
	localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

endpackage

/* hdl/pmc_power_mode_controller.sv */
// Operating-mode controller: run, wait, background, stop3 and stop2, with
// debug command gating and stop2 I/O latch recovery.
// Assumes all inputs are synchronous to clock and that the CPU core reports
// each mode-entry instruction as a one-cycle pulse.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module pmc_power_mode_controller
(
	// Clock, reset and freeze
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	// APB slave
	input  wire logic [pmc_pkg::APB_AW-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [pmc_pkg::APB_DW-1:0] pwdata,
	output logic      [pmc_pkg::APB_DW-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	// CPU core events
	input  wire logic                       wait_exec,
	input  wire logic                       stop_exec,
	input  wire logic                       halt_to_debug_instruction,
	input  wire logic                       irq_req,
	output logic                            cpu_clock_en,
	output logic                            bus_clock_en,
	output logic                            fetch_enable,
	output logic                            cpu_suspended,
	output logic                            clear_irq_mask,
	output logic                            irq_stack_start,
	output logic                            illegal_opcode_reset,
	output logic                            restart_from_por,
	// Debug side
	input  wire logic                       debug_mode_select_pin,
	input  wire logic                       force_reset_release,
	input  wire logic                       debug_enable,
	input  wire logic                       debug_ctrl_break,
	input  wire logic                       debugger_break,
	input  wire logic                       cmd_valid,
	input  wire pmc_pkg::pmc_cmd_t          cmd_code,
	output pmc_pkg::pmc_resp_t              cmd_resp,
	output logic                            debug_clock_en,
	// Wake sources and oscillator
	input  wire logic                       wake_pin_n,
	input  wire logic                       rtc_wake_enable,
	input  wire logic                       rtc_wake_req,
	input  wire logic                       osc_active,
	input  wire logic                       high_gain_osc,
	input  wire logic                       osc_high_range,
	output logic                            osc_run_in_stop,
	// Power and I/O
	output pmc_pkg::pmc_reg_t               regulator_mode,
	output logic                            io_latch_hold,
	output logic                            logic_power_off,
	output pmc_pkg::pmc_mode_t              mode_out
);

	pmc_pkg::pmc_mode_t  mode;
	pmc_pkg::pmc_mode_t  next_mode;
	pmc_pkg::pmc_ctrl_t  ctrl;
	pmc_pkg::pmc_ctrl_t  wr_val;
	logic                regulator_standby_status;
	logic                powerdown_recovery_flag;
	logic                wake_full_latched;
	logic                stop3_debug;
	logic                stop3_full_reg;
	logic                osc_keep_latched;
	logic                por_check;
	logic                wr_en;
	logic                rd_setup;
	logic                ack_write;
	logic                ctrl_write;
	logic                debug_event;
	logic                cmd_alive;
	logic                cmd_is_bkgd;
	logic                cmd_is_go;
	logic                stop2_wake;
	logic                lp_full_wake;
	logic                lp_req_ok;
	logic                ppd_ok;
	logic                debug_clk;
	pmc_pkg::pmc_mode_t  stop_target;

	// Bus side. The slave answers without wait states unless frozen.
	assign pready     = clk_en;
	assign wr_en      = psel & penable & pwrite & clk_en;
	assign rd_setup   = psel & ~penable & ~pwrite & clk_en;
	assign ctrl_write = wr_en & (paddr == pmc_pkg::OFFS_CTRL);
	assign ack_write  = wr_en & (paddr == pmc_pkg::OFFS_ACK) & pwdata[pmc_pkg::ACK_BIT];
	assign wr_val     = pmc_pkg::pmc_ctrl_t'(pwdata[pmc_pkg::CTRL_W-1:0]);

	always_comb
	begin
		if ((paddr == pmc_pkg::OFFS_CTRL) || (paddr == pmc_pkg::OFFS_STATUS)
			|| (paddr == pmc_pkg::OFFS_ACK))
			pslverr = 1'b0;
		else
			pslverr = psel & penable;
	end

	// Read data is captured in the setup cycle so that it comes from flops.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= pmc_pkg::RD_ZERO;
		else if (rd_setup)
		begin
			prdata <= pmc_pkg::RD_ZERO;
			if (paddr == pmc_pkg::OFFS_CTRL)
				prdata[pmc_pkg::CTRL_W-1:0] <= ctrl;
			else if (paddr == pmc_pkg::OFFS_STATUS)
			begin
				prdata[pmc_pkg::STAT_MODE_LSB +: 3] <= mode;
				prdata[pmc_pkg::STAT_STBY_BIT]      <= regulator_standby_status;
				prdata[pmc_pkg::STAT_RCVR_BIT]      <= powerdown_recovery_flag;
				prdata[pmc_pkg::STAT_IOHOLD_BIT]    <= io_latch_hold;
				prdata[pmc_pkg::STAT_DBGCLK_BIT]    <= debug_clk;
			end
		end
	end

	// Debug commands are only heard while the debug clock runs.
	assign debug_clk   = (mode == pmc_pkg::MODE_STOP3) ? stop3_debug
		: (mode != pmc_pkg::MODE_STOP2);
	assign cmd_alive   = cmd_valid & debug_clk;
	assign cmd_is_bkgd = cmd_alive & (cmd_code == pmc_pkg::CMD_BACKGROUND);
	assign cmd_is_go   = cmd_alive & (cmd_code == pmc_pkg::CMD_GO)
		& (mode == pmc_pkg::MODE_BKGD);

	// Strap sampled at the first enabled edge after reset release.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			por_check <= 1'b1;
		else if (clk_en)
			por_check <= 1'b0;
	end

	assign debug_event = (por_check & ~debug_mode_select_pin)
		| (force_reset_release & ~debug_mode_select_pin)
		| cmd_is_bkgd | halt_to_debug_instruction | debug_ctrl_break
		| debugger_break;

	// Stop mode choice from the option bits.
	always_comb
	begin
		if (debug_enable)
			stop_target = pmc_pkg::MODE_STOP3;
		else if (ctrl.lowvolt_detect_enable & ctrl.lowvolt_detect_in_stop)
			stop_target = pmc_pkg::MODE_STOP3;
		else if (ctrl.partial_powerdown_select)
			stop_target = pmc_pkg::MODE_STOP2;
		else
			stop_target = pmc_pkg::MODE_STOP3;
	end

	assign stop2_wake = ~wake_pin_n | (rtc_wake_enable & rtc_wake_req);

	always_comb
	begin
		next_mode = mode;
		case (mode)
			pmc_pkg::MODE_RUN:
			begin
				if (debug_event)
					next_mode = pmc_pkg::MODE_BKGD;
				else if (stop_exec & ctrl.stop_instruction_allow)
					next_mode = stop_target;
				else if (wait_exec)
					next_mode = pmc_pkg::MODE_WAIT;
			end
			pmc_pkg::MODE_WAIT:
			begin
				if (cmd_is_bkgd)
					next_mode = pmc_pkg::MODE_BKGD;
				else if (irq_req)
					next_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_BKGD:
			begin
				if (cmd_is_go)
					next_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_STOP3:
			begin
				if (cmd_is_bkgd)
					next_mode = pmc_pkg::MODE_BKGD;
				else if (irq_req)
					next_mode = pmc_pkg::MODE_RUN;
			end
			pmc_pkg::MODE_STOP2:
			begin
				if (stop2_wake)
					next_mode = pmc_pkg::MODE_RUN;
			end
			default:
				next_mode = pmc_pkg::MODE_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			mode <= pmc_pkg::MODE_RUN;
		else if (clk_en)
			mode <= next_mode;
	end

	// Options caught at stop and wait entry.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wake_full_latched <= 1'b0;
			stop3_debug       <= 1'b0;
			stop3_full_reg    <= 1'b0;
			osc_keep_latched  <= 1'b0;
		end
		else if (clk_en && mode == pmc_pkg::MODE_RUN && !debug_event)
		begin
			if (wait_exec || stop_exec)
				wake_full_latched <= ctrl.wake_to_full_regulation;
			if (stop_exec)
			begin
				stop3_debug      <= debug_enable;
				stop3_full_reg   <= debug_enable
					| (ctrl.lowvolt_detect_enable & ctrl.lowvolt_detect_in_stop);
				osc_keep_latched <= osc_active & ~high_gain_osc & ~osc_high_range;
			end
		end
	end

	// An interrupt out of a low-power wait or stop3 with the wake option set.
	assign lp_full_wake = clk_en & irq_req & wake_full_latched & ~cmd_is_bkgd
		& ((mode == pmc_pkg::MODE_WAIT) | (mode == pmc_pkg::MODE_STOP3));

	// The low-power request and partial powerdown select exclude each other.
	assign ppd_ok = wr_val.partial_powerdown_select & ~ctrl.low_power_run_request;
	assign lp_req_ok = wr_val.low_power_run_request & ~ctrl.partial_powerdown_select & ~ppd_ok
		& (mode != pmc_pkg::MODE_BKGD)
		& ~(wr_val.lowvolt_detect_enable & wr_val.lowvolt_detect_in_stop);

	// Power control survives a stop2 wake; the asynchronous reset clears it, and a full-regulation wake clears the low-power request.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ctrl <= pmc_pkg::CTRL_RESET;
		else if (lp_full_wake)
			ctrl.low_power_run_request <= 1'b0;
		else if (ctrl_write)
		begin
			ctrl                          <= wr_val;
			ctrl.low_power_run_request    <= lp_req_ok;
			ctrl.partial_powerdown_select <= ppd_ok;
		end
	end

	// Status follows the request one cycle behind; a wait keeps it standby.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			regulator_standby_status <= 1'b0;
		else if (lp_full_wake)
			regulator_standby_status <= 1'b0;
		else if (clk_en)
			regulator_standby_status <= ctrl.low_power_run_request;
	end

	// Recovery flag and I/O hold. Entry sets the hold, the wake sets the flag,
	// and the acknowledge clears both; a set in the same cycle wins.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			powerdown_recovery_flag <= 1'b0;
			io_latch_hold           <= 1'b0;
		end
		else if (clk_en)
		begin
			if (mode == pmc_pkg::MODE_STOP2 && stop2_wake)
				powerdown_recovery_flag <= 1'b1;
			else if (ack_write)
				powerdown_recovery_flag <= 1'b0;
			if (next_mode == pmc_pkg::MODE_STOP2)
				io_latch_hold <= 1'b1;
			else if (ack_write)
				io_latch_hold <= 1'b0;
		end
	end

	// One-cycle pulses to the core and the reset logic.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clear_irq_mask       <= 1'b0;
			irq_stack_start      <= 1'b0;
			illegal_opcode_reset <= 1'b0;
			restart_from_por     <= 1'b0;
		end
		else if (clk_en)
		begin
			clear_irq_mask       <= (mode == pmc_pkg::MODE_RUN) & ~debug_event
				& ~stop_exec & wait_exec;
			irq_stack_start      <= irq_req & ~cmd_is_bkgd
				& ((mode == pmc_pkg::MODE_WAIT) | (mode == pmc_pkg::MODE_STOP3));
			illegal_opcode_reset <= (mode == pmc_pkg::MODE_RUN) & ~debug_event
				& stop_exec & ~ctrl.stop_instruction_allow;
			restart_from_por     <= (mode == pmc_pkg::MODE_STOP2) & stop2_wake;
		end
		else
		begin
			clear_irq_mask       <= 1'b0;
			irq_stack_start      <= 1'b0;
			illegal_opcode_reset <= 1'b0;
			restart_from_por     <= 1'b0;
		end
	end

	// Command answers, one cycle after the command.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cmd_resp <= pmc_pkg::RESP_IDLE;
		else if (clk_en)
		begin
			cmd_resp       <= pmc_pkg::RESP_IDLE;
			cmd_resp.valid <= cmd_alive;
			if (cmd_alive)
			begin
				case (mode)
					pmc_pkg::MODE_BKGD:
						cmd_resp.exec <= 1'b1;
					pmc_pkg::MODE_RUN:
						cmd_resp.exec <= (cmd_code == pmc_pkg::CMD_MEM)
							| (cmd_code == pmc_pkg::CMD_MEM_STAT)
							| (cmd_code == pmc_pkg::CMD_DREG)
							| (cmd_code == pmc_pkg::CMD_BACKGROUND);
					default:
					begin
						cmd_resp.exec     <= (cmd_code == pmc_pkg::CMD_BACKGROUND);
						cmd_resp.mode_err <= (cmd_code == pmc_pkg::CMD_MEM_STAT);
					end
				endcase
			end
		end
		else
			cmd_resp <= pmc_pkg::RESP_IDLE;
	end

	// Clock, power and regulator controls follow the mode.
	assign cpu_clock_en    = (mode == pmc_pkg::MODE_RUN);
	assign fetch_enable    = (mode == pmc_pkg::MODE_RUN);
	assign cpu_suspended   = (mode == pmc_pkg::MODE_BKGD);
	assign bus_clock_en    = (mode != pmc_pkg::MODE_STOP3)
		& (mode != pmc_pkg::MODE_STOP2);
	assign debug_clock_en  = debug_clk;
	assign logic_power_off = (mode == pmc_pkg::MODE_STOP2);
	assign mode_out        = mode;
	assign osc_run_in_stop = (mode == pmc_pkg::MODE_STOP2) ? osc_keep_latched
		: ctrl.ext_ref_stop_keep;

	always_comb
	begin
		if (mode == pmc_pkg::MODE_STOP2)
			regulator_mode = pmc_pkg::REG_PARTIAL;
		else if (mode == pmc_pkg::MODE_STOP3)
			regulator_mode = stop3_full_reg ? pmc_pkg::REG_FULL
				: pmc_pkg::REG_STANDBY;
		else if (regulator_standby_status)
			regulator_mode = pmc_pkg::REG_STANDBY;
		else
			regulator_mode = pmc_pkg::REG_FULL;
	end

	// Checks.
	a_stop_refused: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_RUN && !debug_event && stop_exec
			&& !ctrl.stop_instruction_allow)
		|=> (illegal_opcode_reset && mode == pmc_pkg::MODE_RUN))
		else $error("stop while disallowed did not force illegal reset");

	a_wait_entry: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_RUN && !debug_event && !stop_exec && wait_exec)
		|=> (mode == pmc_pkg::MODE_WAIT && clear_irq_mask && !cpu_clock_en))
		else $error("wait entry wrong");

	a_wait_irq_exit: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_WAIT && irq_req && !cmd_is_bkgd)
		|=> (mode == pmc_pkg::MODE_RUN && irq_stack_start))
		else $error("interrupt did not leave wait");

	a_wait_bkgd_cmd: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_WAIT && cmd_is_bkgd)
		|=> (mode == pmc_pkg::MODE_BKGD && cpu_suspended && cmd_resp.exec))
		else $error("background command did not enter background mode");

	a_wait_status_err: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_WAIT && cmd_valid
			&& cmd_code == pmc_pkg::CMD_MEM_STAT)
		|=> (cmd_resp.valid && cmd_resp.mode_err && !cmd_resp.exec))
		else $error("status memory command in wait did not error");

	a_lp_full_wake: assert property (@(posedge clock) disable iff (!rst_n)
		lp_full_wake |=> (!ctrl.low_power_run_request && !regulator_standby_status
			&& mode == pmc_pkg::MODE_RUN))
		else $error("full regulation wake did not clear low-power bits");

	a_stop_debug: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_RUN && !debug_event && stop_exec
			&& ctrl.stop_instruction_allow && debug_enable)
		|=> (mode == pmc_pkg::MODE_STOP3 && debug_clock_en
			&& regulator_mode == pmc_pkg::REG_FULL))
		else $error("stop with debug enabled not stop3 with debug clock");

	a_stop_clocks: assert property (@(posedge clock) disable iff (!rst_n)
		(mode == pmc_pkg::MODE_STOP2) |-> (!bus_clock_en && !cpu_clock_en
			&& regulator_mode == pmc_pkg::REG_PARTIAL && io_latch_hold && logic_power_off))
		else $error("stop2 outputs wrong");

	a_powerdown_recovery_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
		(powerdown_recovery_flag && !ack_write) |=> (powerdown_recovery_flag && io_latch_hold))
		else $error("recovery flag or latch released without acknowledge");

	a_stop2_wake: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && mode == pmc_pkg::MODE_STOP2 && stop2_wake)
		|=> (restart_from_por && powerdown_recovery_flag && mode == pmc_pkg::MODE_RUN))
		else $error("stop2 wake did not restart");

	c_stop2_cycle: cover property (@(posedge clock) disable iff (!rst_n)
		mode == pmc_pkg::MODE_STOP2 ##1 mode == pmc_pkg::MODE_RUN ##[1:20] ack_write);
	c_debug_go: cover property (@(posedge clock) disable iff (!rst_n)
		mode == pmc_pkg::MODE_BKGD ##1 mode == pmc_pkg::MODE_RUN);
	c_lp_wait: cover property (@(posedge clock) disable iff (!rst_n)
		mode == pmc_pkg::MODE_WAIT && regulator_mode == pmc_pkg::REG_STANDBY);

endmodule

/* verif/pmc_wake_model.sv */
// Wake sources beside the controller: the shared board wake pin and the counter.
// Assumes the bench raises each wake request for one cycle after a rising edge.
module pmc_wake_model
(
	// Requests from the bench
	input  wire logic press,
	input  wire logic rtc_fire,
	// Wake lines into the controller
	output logic      wake_pin_n,
	output logic      rtc_wake_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// No pull-up comes from the controller, so the board resistor holds the pin high.
	assign wake_pin_n   = ~press;
	assign rtc_wake_req = rtc_fire;
endmodule

/* verif/tb_top.sv */
// Self-checking bench of the power mode controller, with APB and event drivers.
// Assumes pmc_pkg and the wake model are compiled first.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clock, rst_n, clk_en, psel, penable, pwrite, wait_exec, stop_exec;
	logic               halt_to_debug_instruction, force_reset_release, debug_enable, irq_req;
	logic               debug_mode_select_pin, debug_ctrl_break, debugger_break, cmd_valid;
	logic               rtc_wake_enable, press, rtc_fire, osc_active, high_gain_osc, er;
	logic               osc_high_range, wake_pin_n, rtc_wake_req, pready, pslverr;
	logic               cpu_clock_en, bus_clock_en, fetch_enable, cpu_suspended, clear_irq_mask;
	logic               irq_stack_start, illegal_opcode_reset, restart_from_por, debug_clock_en;
	logic               osc_run_in_stop, io_latch_hold, logic_power_off;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	pmc_pkg::pmc_cmd_t  cmd_code;
	pmc_pkg::pmc_resp_t cmd_resp;
	pmc_pkg::pmc_reg_t  regulator_mode;
	pmc_pkg::pmc_mode_t mode_out;
	int                 failures, n_checks;

	pmc_power_mode_controller uut (.clock, .rst_n, .clk_en, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .wait_exec, .stop_exec, .halt_to_debug_instruction,
		.irq_req, .cpu_clock_en, .bus_clock_en, .fetch_enable, .cpu_suspended, .clear_irq_mask,
		.irq_stack_start, .illegal_opcode_reset, .restart_from_por, .debug_mode_select_pin,
		.force_reset_release, .debug_enable, .debug_ctrl_break, .debugger_break, .cmd_valid,
		.cmd_code, .cmd_resp, .debug_clock_en, .wake_pin_n, .rtc_wake_enable, .rtc_wake_req,
		.osc_active, .high_gain_osc, .osc_high_range, .osc_run_in_stop, .regulator_mode,
		.io_latch_hold, .logic_power_off, .mode_out);
	pmc_wake_model wake (.press, .rtc_fire, .wake_pin_n, .rtc_wake_req);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task end_of_test;
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clock);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			failures++;
			$display("BAD %0t no pready", $time);
			end_of_test();
		end
	endtask

	// The pin strap follows the request so a forced-reset release sees it low.
	task pulse(input int k, input pmc_pkg::pmc_cmd_t c);
		@(posedge clock);
		cmd_code              <= c;
		debug_mode_select_pin <= (k != 5);
		case (k)
			0: wait_exec <= 1'b1;
			1: stop_exec <= 1'b1;
			2: halt_to_debug_instruction <= 1'b1;
			3: debug_ctrl_break <= 1'b1;
			4: debugger_break <= 1'b1;
			5: force_reset_release <= 1'b1;
			6: cmd_valid <= 1'b1;
			7: irq_req <= 1'b1;
			8: press <= 1'b1;
			default: rtc_fire <= 1'b1;
		endcase
		@(posedge clock);
		{wait_exec, stop_exec, halt_to_debug_instruction, debug_ctrl_break, debugger_break,
			force_reset_release, cmd_valid, irq_req, press, rtc_fire} <= '0;
		debug_mode_select_pin <= 1'b1;
		#1;
	endtask

	task rst(input logic pin);
		@(posedge clock);
		rst_n                 <= 1'b0;
		debug_mode_select_pin <= pin;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		debug_mode_select_pin <= 1'b1;
		#1;
		chk(mode_out, pin ? pmc_pkg::MODE_RUN : pmc_pkg::MODE_BKGD);
	endtask

	// Walking down the codes puts the intrusive ones and the background command in run and the rest in background.
	task t_cmds;
		int c;
		for (c = 6; c >= 0; c--)
		begin
			pulse(6, pmc_pkg::pmc_cmd_t'(c[2:0]));
			chk(cmd_resp, {1'b1, c < 4, 1'b0});
		end
		pulse(6, pmc_pkg::CMD_TRACE);
		chk(cmd_resp, 3'b110);
		pulse(6, pmc_pkg::CMD_GO);
		chk({mode_out, cmd_resp}, {pmc_pkg::MODE_RUN, 3'b110});
	endtask

	task t_triggers;
		int k;
		for (k = 2; k < 6; k++)
		begin
			rst(1'b1);
			pulse(k, pmc_pkg::CMD_MEM);
			chk(mode_out, pmc_pkg::MODE_BKGD);
			chk({cpu_suspended, fetch_enable, cpu_clock_en}, 3'b100);
		end
		rst(1'b0);
	endtask

	task t_wait;
		rst(1'b1);
		pulse(0, pmc_pkg::CMD_MEM);
		chk({mode_out, cpu_clock_en, clear_irq_mask}, {pmc_pkg::MODE_WAIT, 2'b01});
		pulse(6, pmc_pkg::CMD_MEM_STAT);
		chk(cmd_resp, 3'b101);
		pulse(6, pmc_pkg::CMD_MEM);
		chk(cmd_resp, 3'b100);
		pulse(7, pmc_pkg::CMD_MEM);
		chk({mode_out, irq_stack_start}, {pmc_pkg::MODE_RUN, 1'b1});
		pulse(0, pmc_pkg::CMD_MEM);
		pulse(6, pmc_pkg::CMD_BACKGROUND);
		chk({mode_out, cmd_resp}, {pmc_pkg::MODE_BKGD, 3'b110});
	endtask

	task t_lowpower;
		rst(1'b1);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd[30:0]}, {1'b1, 31'h0});
		apb(1'b1, pmc_pkg::OFFS_CTRL, 32'h0000_0010);
		apb(1'b0, pmc_pkg::OFFS_STATUS, 32'h0);
		chk({rd[4], regulator_mode}, {1'b1, pmc_pkg::REG_STANDBY});
		pulse(0, pmc_pkg::CMD_MEM);
		chk({mode_out, regulator_mode}, {pmc_pkg::MODE_WAIT, pmc_pkg::REG_STANDBY});
		pulse(7, pmc_pkg::CMD_MEM);
		apb(1'b0, pmc_pkg::OFFS_CTRL, 32'h0);
		chk({rd[5:0], regulator_mode}, {6'h10, pmc_pkg::REG_STANDBY});
		apb(1'b1, pmc_pkg::OFFS_CTRL, 32'h0000_0030);
		pulse(0, pmc_pkg::CMD_MEM);
		pulse(7, pmc_pkg::CMD_MEM);
		apb(1'b0, pmc_pkg::OFFS_CTRL, 32'h0);
		chk({rd[5:0], regulator_mode}, {6'h20, pmc_pkg::REG_FULL});
		apb(1'b0, pmc_pkg::OFFS_STATUS, 32'h0);
		chk(rd[4], 1'b0);
		apb(1'b1, pmc_pkg::OFFS_CTRL, 32'h0000_0010);
		pulse(0, pmc_pkg::CMD_MEM);
		rst(1'b1);
		apb(1'b0, pmc_pkg::OFFS_CTRL, 32'h0);
		chk({rd[5:0], regulator_mode}, {6'h00, pmc_pkg::REG_FULL});
	endtask

	// A set rg[2] means the regulator is not judged and the debug clock is instead.
	task do_stop(input logic [31:0] c, input logic d, input pmc_pkg::pmc_mode_t m,
		input logic [2:0] rg);
		rst(1'b1);
		@(posedge clock);
		debug_enable <= d;
		apb(1'b1, pmc_pkg::OFFS_CTRL, c);
		pulse(1, pmc_pkg::CMD_MEM);
		chk({illegal_opcode_reset, mode_out, bus_clock_en}, {m == 3'h0, m, m == 3'h0});
		if (rg[2])
			chk(debug_clock_en, 1'b1);
		else
			chk(regulator_mode, rg[1:0]);
		pulse(7, pmc_pkg::CMD_MEM);
		chk({mode_out, irq_stack_start}, {pmc_pkg::MODE_RUN, m != 3'h0});
	endtask

	// A low enable must freeze the mode, hold back the pulses and stall the bus.
	task t_freeze;
		rst(1'b1);
		@(posedge clock);
		clk_en <= 1'b0;
		pulse(0, pmc_pkg::CMD_MEM);
		chk({mode_out, clear_irq_mask, pready}, {pmc_pkg::MODE_RUN, 2'b00});
		clk_en <= 1'b1;
	endtask

	task t_stop2(input logic r);
		rst(1'b1);
		@(posedge clock);
		debug_enable    <= 1'b0;
		osc_active      <= 1'b1;
		rtc_wake_enable <= r;
		apb(1'b1, pmc_pkg::OFFS_CTRL, 32'h0000_0009);
		pulse(1, pmc_pkg::CMD_MEM);
		chk({mode_out, bus_clock_en}, {pmc_pkg::MODE_STOP2, 1'b0});
		chk(regulator_mode, pmc_pkg::REG_PARTIAL);
		chk({io_latch_hold, logic_power_off, osc_run_in_stop}, 3'b111);
		if (!r)
		begin
			pulse(9, pmc_pkg::CMD_MEM);
			chk(mode_out, pmc_pkg::MODE_STOP2);
		end
		pulse(r ? 9 : 8, pmc_pkg::CMD_MEM);
		chk({mode_out, restart_from_por, io_latch_hold}, {pmc_pkg::MODE_RUN, 2'b11});
		apb(1'b0, pmc_pkg::OFFS_CTRL, 32'h0);
		chk(rd, 32'h0000_0009);
		apb(1'b0, pmc_pkg::OFFS_STATUS, 32'h0);
		chk(rd[6:5], 2'b11);
		apb(1'b1, pmc_pkg::OFFS_ACK, 32'h0000_0001);
		apb(1'b0, pmc_pkg::OFFS_STATUS, 32'h0);
		chk({rd[6:5], io_latch_hold}, 3'b000);
	endtask

	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, wait_exec, stop_exec, irq_req, cmd_code,
			halt_to_debug_instruction, force_reset_release, debug_enable, debug_ctrl_break,
			debugger_break, cmd_valid, rtc_wake_enable, press, rtc_fire, osc_active,
			high_gain_osc, osc_high_range, failures, n_checks} = '0;
		clk_en                = 1'b1;
		debug_mode_select_pin = 1'b1;
		rst(1'b1);
		t_cmds();
		t_triggers();
		t_freeze();
		t_wait();
		t_lowpower();
		do_stop(32'h0000_0008, 1'b0, pmc_pkg::MODE_RUN, 3'h0);
		do_stop(32'h0000_000f, 1'b0, pmc_pkg::MODE_STOP3, 3'h0);
		do_stop(32'h0000_0001, 1'b0, pmc_pkg::MODE_STOP3, 3'h1);
		do_stop(32'h0000_000f, 1'b1, pmc_pkg::MODE_STOP3, 3'h4);
		t_stop2(1'b0);
		t_stop2(1'b1);
		end_of_test();
	end
endmodule
